// ===== hdl/pxc_code_map.sv
`default_nettype none
module pxc_code_map
	import pxc_pkg::*;
(
	input wire logic [3:0] nibble,
	input wire logic force_invalid,
	output logic [4:0] code
);
	// Standard 4B/5B data code table
	function automatic logic [4:0] pxc_std(input logic [3:0] n);
		unique case (n)
			4'h0: pxc_std = 5'h1e;
			4'h1: pxc_std = 5'h09;
			4'h2: pxc_std = 5'h14;
			4'h3: pxc_std = 5'h15;
			4'h4: pxc_std = 5'h0a;
			4'h5: pxc_std = 5'h0b;
			4'h6: pxc_std = 5'h0e;
			4'h7: pxc_std = 5'h0f;
			4'h8: pxc_std = 5'h12;
			4'h9: pxc_std = 5'h13;
			4'ha: pxc_std = 5'h16;
			4'hb: pxc_std = 5'h17;
			4'hc: pxc_std = 5'h1a;
			4'hd: pxc_std = 5'h1b;
			4'he: pxc_std = 5'h1c;
			default: pxc_std = 5'h1d;
		endcase
	endfunction : pxc_std

	// Raw test codes, reachable only under the test condition
	function automatic logic [4:0] pxc_raw(input logic [3:0] n);
		unique case (n)
			4'h8: pxc_raw = 5'h00;
			4'h9: pxc_raw = 5'h0d;
			4'ha: pxc_raw = 5'h0c;
			4'hb: pxc_raw = 5'h11;
			4'hc: pxc_raw = 5'h10;
			4'hd: pxc_raw = 5'h19;
			4'he: pxc_raw = 5'h18;
			4'hf: pxc_raw = 5'h1f;
			default: pxc_raw = {1'b0, n};
		endcase
	endfunction : pxc_raw

	// Select table
	always_comb begin
		if (force_invalid) begin
			code = pxc_raw(nibble);
		end else begin
			code = pxc_std(nibble);
		end
	end
endmodule : pxc_code_map
`default_nettype wire

// ===== hdl/pxc_ext_ctrl.sv
`default_nettype none
module pxc_ext_ctrl
	import pxc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic soft_reset,
	input wire logic [4:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	output logic override_protected_bit,
	input wire logic addr4_led_pin,
	input wire logic addr3_led_pin,
	input wire logic addr2_led_pin,
	input wire logic addr1_led_pin,
	input wire logic addr0_led_pin,
	input wire logic speed_100,
	input wire logic [3:0] tx_nibble,
	input wire logic tx_err,
	output logic [4:0] tx_code,
	output logic force_unlock,
	output logic nrzi_en,
	output logic scramble_en,
	output logic descramble_en,
	output logic [4:0] phy_addr
);
	////////////////////////////////////////////////////////////////
	logic rst_m_q;
	logic rst_s_q;
	logic [15:0] ctrl_q;
	logic [4:0] addr_q;
	logic cap_q;
	logic [4:0] code_d;
	logic hit_wr;
	logic [15:0] reg_view;
	logic hit_rd;
	logic [4:0] strap_pins;
	logic [4:0] strap_s1_q;
	logic [4:0] strap_s2_q;
	logic [4:0] strap_s3_q;
	logic [4:0] strap_q;
	logic force_invalid_d;
	logic cipher_on;

	// True when an access names this register; every other address
	// reads back as zero, and a write there clears only the override bit
	function automatic logic pxc_hit(input logic [4:0] a);
		pxc_hit = (a == PXC_REG_ADDR);
	endfunction : pxc_hit

	// Line coding only runs at the fast rate; the slow rate must
	// never see these controls raised
	function automatic logic pxc_fast(input logic fast, input logic en);
		pxc_fast = fast & en;
	endfunction : pxc_fast

	// Reset release through two flops, so every reset flop below leaves
	// reset on the same clean edge; the strap stages have no reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end

	// Access decode, shared by the write and read paths
	assign hit_wr = mgmt_wr && pxc_hit(mgmt_addr);
	assign hit_rd = mgmt_rd && pxc_hit(mgmt_addr);

	////////////////////////////////////////////////////////////////
	// Strap pins gathered into one word, address bit 4 on top; they
	// share their pins with the lamps once reset is over
	assign strap_pins = {addr4_led_pin, addr3_led_pin, addr2_led_pin,
		addr1_led_pin, addr0_led_pin};

	// Straps are asynchronous to mclk; the stages run free, also in
	// reset, so a settled level is waiting when the capture edge comes
	always_ff @(posedge mclk) begin
		strap_s1_q <= strap_pins;
		strap_s2_q <= strap_s1_q;
		strap_s3_q <= strap_s2_q;
	end

	// A level only counts once the last two stages agree, so a pin
	// caught mid-swing cannot leak a half-settled address bit
	always_ff @(posedge mclk) begin
		if (strap_s2_q == strap_s3_q) begin
			strap_q <= strap_s3_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Address straps: caught on the first edge after reset release;
	// soft reset cannot touch them. Limitation: the straps must sit
	// still for four clocks before that edge
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			addr_q <= 5'h00;
			cap_q <= 1'b1;
		end else if (cap_q) begin
			addr_q <= strap_q;
			cap_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control bits; address and reserved write data dropped, and a
	// soft reset in the same clock as a write wins over it
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			ctrl_q <= PXC_RESET_VAL;
		end else if (soft_reset) begin
			ctrl_q <= PXC_RESET_VAL;
		end else if (hit_wr) begin
			ctrl_q <= mgmt_wdata & PXC_WR_MASK;
		end else if (mgmt_wr) begin
			ctrl_q[PXC_BIT_OVR] <= 1'b0;
		end
	end

	// Enable holds until a soft reset or a write to another address clears it; a write
	// to this register loads it from the written bit 15
	assign override_protected_bit = ctrl_q[PXC_BIT_OVR];

	// Register as the station sees it: stored bits with the strap
	// latch laid over the address field
	always_comb begin
		reg_view = ctrl_q;
		reg_view[PXC_ADDR_HI:PXC_ADDR_LO] = addr_q;
	end

	////////////////////////////////////////////////////////////////
	// Read data registered on a read strobe; it stands until the next
	// read, so a slow station may pick it up late
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			mgmt_rdata <= 16'h0000;
		end else if (mgmt_rd) begin
			mgmt_rdata <= hit_rd ? reg_view : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// Raw test codes only while the test bit and transmit error meet;
	// at any other time every nibble takes the standard table
	assign force_invalid_d = ctrl_q[PXC_BIT_INV_CODE] & tx_err;

	pxc_code_map u_map (
		.nibble(tx_nibble),
		.force_invalid(force_invalid_d),
		.code(code_d)
	);

	// Transmit code, one clock behind its nibble; registering it keeps
	// the table decode off the serialiser's timing path
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			tx_code <= 5'h00;
		end else begin
			tx_code <= code_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Descrambler loses lock for as long as the test bit stays set;
	// clearing the bit lets it find lock again on live data
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			force_unlock <= 1'b0;
		end else begin
			force_unlock <= ctrl_q[PXC_BIT_SCR_TEST];
		end
	end

	// NRZI only at the fast rate; at the slow rate the stored bit is
	// kept but has no effect on the line
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			nrzi_en <= 1'b0;
		end else begin
			nrzi_en <= pxc_fast(speed_100, ctrl_q[PXC_BIT_NRZI]);
		end
	end

	// One cipher bit drives both directions, so the two paths can
	// never disagree about whether the line is scrambled
	assign cipher_on = ~ctrl_q[PXC_BIT_CIPHER_DIS];

	// Transmit scrambler, fast rate only; a set disable bit sends
	// plain data and idles
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			scramble_en <= 1'b0;
		end else begin
			scramble_en <= pxc_fast(speed_100, cipher_on);
		end
	end

	// Receive descrambler, fast rate only; follows the same bit as
	// the transmit side
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			descramble_en <= 1'b0;
		end else begin
			descramble_en <= pxc_fast(speed_100, cipher_on);
		end
	end

	// Latched address copied out; it follows the capture by one clock
	// and a soft reset never reaches it
	always_ff @(posedge mclk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			phy_addr <= 5'h00;
		end else begin
			phy_addr <= addr_q;
		end
	end
endmodule : pxc_ext_ctrl
`default_nettype wire

// ===== inc/pxc_pkg.sv
`default_nettype none
package pxc_pkg;
	localparam logic [4:0] PXC_REG_ADDR = 5'h10;
	localparam int PXC_BIT_OVR = 15;
	localparam int PXC_ADDR_HI = 10;
	localparam int PXC_ADDR_LO = 6;
	localparam int PXC_BIT_SCR_TEST = 5;
	localparam int PXC_BIT_NRZI = 3;
	localparam int PXC_BIT_INV_CODE = 2;
	localparam int PXC_BIT_CIPHER_DIS = 0;
	// Bits that a write can store; address and reserved bits excluded
	localparam logic [15:0] PXC_WR_MASK = 16'h802d;
	localparam logic [15:0] PXC_RESET_VAL = 16'h0008;
endpackage : pxc_pkg
`default_nettype wire

// ===== sim/phy_extended_control_register_bench.sv
`default_nettype none
module phy_extended_control_register_bench;
	import pxc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_b = 0, soft_reset = 0, speed_100 = 1, tx_err = 0;
	logic addr4_led_pin = 1, addr3_led_pin = 0, addr2_led_pin = 1;
	logic addr1_led_pin = 0, addr0_led_pin = 1;
	logic [3:0] tx_nibble = 4'h0;
	logic [4:0] mgmt_addr, tx_code, phy_addr;
	logic mgmt_wr, mgmt_rd, override_protected_bit, force_unlock;
	logic nrzi_en, scramble_en, descramble_en;
	logic [15:0] mgmt_wdata, mgmt_rdata, q;
	int fails = 0, samples_checked = 0;
	pxc_ext_ctrl DUT (.*);
	pxc_sta_model sta (.*);
	initial forever #5 mclk = ~mclk;
	task automatic cmp(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic ctl(input logic [3:0] exp);
		@(posedge mclk) #1;
		cmp({force_unlock, nrzi_en, scramble_en, descramble_en}, exp);
	endtask : ctl
	// Strapped address 0x15 lands in bits 10:6
	task automatic t_reset;
		sta.xfer(0, PXC_REG_ADDR, 0, q);
		cmp(q, 16'h0548);
		cmp({11'h0, phy_addr}, 16'h0015);
	endtask : t_reset
	task automatic t_write;
		sta.xfer(1, PXC_REG_ADDR, 16'h07ed, q);
		sta.xfer(0, PXC_REG_ADDR, 0, q);
		cmp(q, 16'h056d);
		ctl(4'b1100);
		speed_100 = 0;
		ctl(4'b1000);
		ctl(4'b1000);
		speed_100 = 1;
		sta.xfer(1, PXC_REG_ADDR, 0, q);
		ctl(4'b0011);
	endtask : t_write
	// Enable only survives until the next write to another address
	task automatic t_ovr;
		sta.xfer(1, PXC_REG_ADDR, 16'h8000, q);
		cmp({15'h0, override_protected_bit}, 16'h0001);
		sta.xfer(0, PXC_REG_ADDR, 0, q);
		cmp(q, 16'h8540);
		sta.xfer(1, 5'h01, 0, q);
		cmp({15'h0, override_protected_bit}, 16'h0000);
		sta.xfer(0, 5'h01, 0, q);
		cmp(q, 16'h0000);
		sta.xfer(0, PXC_REG_ADDR, 0, q);
		cmp(q, 16'h0540);
	endtask : t_ovr
	task automatic t_soft;
		soft_reset = 1;
		@(posedge mclk) #1 soft_reset = 0;
		sta.xfer(0, PXC_REG_ADDR, 0, q);
		cmp(q, 16'h0548);
	endtask : t_soft
	task automatic t_code;
		logic [4:0] hi [8] = '{5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19,
			5'h18, 5'h1f};
		sta.xfer(1, PXC_REG_ADDR, 16'h0004, q);
		tx_err = 1;
		for (int n = 0; n < 16; n++) begin
			tx_nibble = 4'(n);
			@(posedge mclk) #1;
			cmp({11'h0, tx_code}, n < 8 ? 16'(n) : {11'h0, hi[n-8]});
		end
		tx_err = 0;
		tx_nibble = 4'h0;
		@(posedge mclk) #1;
		cmp({11'h0, tx_code}, 16'h001e);
	endtask : t_code
	task automatic finish_test;
		if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	initial begin
		repeat (2) @(posedge mclk);
		#1 rst_b = 1;
		repeat (4) @(posedge mclk);
		#1;
		t_reset();
		t_write();
		t_ovr();
		t_soft();
		t_code();
		finish_test();
	end
	// Watchdog, far beyond the roughly fifty cycles the tests need
	initial begin
		#20000;
		fails++;
		finish_test();
	end
endmodule : phy_extended_control_register_bench
`default_nettype wire

// ===== sim/pxc_ext_ctrl_chk.sv
`default_nettype none
module pxc_ext_chk (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic soft_reset,
	input wire logic [4:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	input wire logic override_protected_bit,
	input wire logic speed_100,
	input wire logic nrzi_en,
	input wire logic scramble_en,
	input wire logic descramble_en,
	input wire logic [4:0] phy_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Read answers, one cycle after the pulse
	rsvd_zero_a: assert property (
		mgmt_rd && mgmt_addr == 5'h10 |=> (mgmt_rdata & 16'h7812) == 0)
		else $error("reserved bits set");
	rd_addr_a: assert property (
		mgmt_rd && mgmt_addr == 5'h10 |=> mgmt_rdata[10:6] == phy_addr)
		else $error("address field wrong");
	rd_other_a: assert property (
		mgmt_rd && mgmt_addr != 5'h10 |=> mgmt_rdata == 0)
		else $error("unmapped read not zero");
	// Override enable is cleared by the next write to another address
	ovr_clear_a: assert property (
		mgmt_wr && mgmt_addr != 5'h10 |=> !override_protected_bit)
		else $error("override not cleared");
	ovr_load_a: assert property (
		mgmt_wr && mgmt_addr == 5'h10 && !soft_reset
		|=> override_protected_bit == $past(mgmt_wdata[15]))
		else $error("override not loaded");
	addr_keep_a: assert property (
		soft_reset |=> $stable(phy_addr)) else $error("address moved");
	slow_off_a: assert property (
		!speed_100 [*2] |-> !nrzi_en && !scramble_en && !descramble_en)
		else $error("coding active at low speed");
	cipher_pair_a: assert property (
		speed_100 [*2] |-> scramble_en == descramble_en)
		else $error("cipher paths differ");
endmodule : pxc_ext_chk
bind pxc_ext_ctrl pxc_ext_chk u_chk (.*);
`default_nettype wire

// ===== sim/pxc_sta_model.sv
`default_nettype none
module pxc_sta_model (
	input wire logic mclk,
	input wire logic [15:0] mgmt_rdata,
	output logic [4:0] mgmt_addr,
	output logic mgmt_wr,
	output logic mgmt_rd,
	output logic [15:0] mgmt_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = '0;
	// One access; lines inverted after so stale values never match
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge mclk) #1;
		mgmt_wdata = d & ~16'h7812;
		{mgmt_wr, mgmt_rd, mgmt_addr} = {w, !w, a};
		@(posedge mclk) #1;
		q = mgmt_rdata;
		{mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = {2'b00, ~a, ~d};
	endtask : xfer
endmodule : pxc_sta_model
`default_nettype wire
